// ### att_pkg.sv
package att_pkg;

  // APB byte addresses of the register words.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GAIN = 8'h04;
  localparam logic [7:0] ADDR_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_ON = 8'h0C;
  localparam logic [7:0] ADDR_DELTA = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_ACT_X = 8'h18;
  localparam logic [7:0] ADDR_ACT_Y = 8'h1C;

  // Parameter limits; gain is held in hundredths.
  localparam logic signed [31:0] GAIN_MIN = -32'sd1000;
  localparam logic signed [31:0] GAIN_MAX = 32'sd1000;
  localparam logic signed [31:0] GAIN_UNITY = 32'sd100;
  localparam logic signed [31:0] OFS_MIN = -32'sd10000;
  localparam logic signed [31:0] OFS_MAX = 32'sd10000;
  localparam logic signed [31:0] THR_MIN = -32'sd20000;
  localparam logic signed [31:0] THR_MAX = 32'sd20000;

  // Physical channel code scaling: full scale code maps to 0..1000.
  localparam int PHYS_CH = 8;
  localparam int NET_CH = 32;
  localparam int BLK_CH = 8;
  localparam int ADC_W = 12;
  localparam logic [31:0] ADC_FULL = 32'd4095;
  localparam logic [31:0] PHYS_SPAN = 32'd1000;

  // Source index ranges of the input selectors.
  localparam logic [5:0] SRC_NET_BASE = 6'h08;
  localparam logic [5:0] SRC_BLK_BASE = 6'h28;
  localparam logic [5:0] SRC_LAST = 6'h2F;

  // Reset values.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic signed [15:0] ZERO16 = 16'sh0000;

  typedef enum logic [1:0] {
    ATT_DIFF_TRIG = 2'b00,
    ATT_COMPARE = 2'b01,
    ATT_REDUCED = 2'b10
  } att_mode_t;

  // Control word layout, bit 31 down to bit 0.
  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic [1:0] decimals;
    logic off_from_blk;
    logic on_from_blk;
    att_mode_t mode;
    logic rsvd_b23;
    logic [2:0] off_blk;
    logic rsvd_b19;
    logic [2:0] on_blk;
    logic [1:0] rsvd_b15;
    logic [5:0] y_sel;
    logic [1:0] rsvd_b7;
    logic [5:0] x_sel;
  } att_cfg_t;

  typedef struct packed {
    logic signed [10:0] gain;
    logic signed [14:0] offset;
    logic signed [15:0] on_thr;
    logic signed [15:0] delta;
  } att_par_t;

endpackage

// ### att_trigger.sv
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
// Behaviour
// - Each selected input is multiplied by gain, then offset is added.
// - Gain -10.00..10.00 in hundredths, offset -10000..10000, writes clamped.
// - Differential trigger takes On and signed delta, each -20000..20000.
// - Differential trigger off threshold is On plus delta.
// - Negative delta: set above On, clear at or below Off.
// - Positive delta: output high only while On <= value < Off.
// - Decimal setting is stored for display only, never used in comparing.
// - Physical channel full scale maps to internal 0..1000.
// - Comparator scales the second input with the same gain and offset.
// - Comparator compares first minus second actual value with thresholds.
// - Comparator thresholds may come live from another function block.
// - Reduced comparator sets output when the difference exceeds delta.
// - Comparator with On >= Off: set above On, clear at or below Off.
// - Comparator with On < Off: high only while On <= difference < Off.
module att_trigger
  import att_pkg::*;
(
  input wire logic pclk, // APB clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [PHYS_CH*ADC_W-1:0] physical_analog_channels, // Converter codes
  input wire logic [NET_CH*16-1:0] network_analog_channels, // Signed values
  input wire logic [BLK_CH*16-1:0] block_values, // Signed block actual values
  output logic trig_q // Threshold output
);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  att_cfg_t cfg_ff;
  att_par_t par_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic q_ff;
  logic signed [31:0] act_x_ff;
  logic signed [31:0] act_y_ff;
  logic [31:0] nxt_prdata;
  logic nxt_slverr;
  logic wr_take;
  logic setup;

  function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                               input logic signed [31:0] lo,
                                               input logic signed [31:0] hi);
    logic signed [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  assign setup = psel && !penable && !pready_ff;
  assign wr_take = psel && penable && pready_ff && pwrite;

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = 1'b0;
    case (paddr)
      ADDR_CTRL: nxt_prdata = cfg_ff;
      ADDR_GAIN: nxt_prdata = 32'(par_ff.gain);
      ADDR_OFFSET: nxt_prdata = 32'(par_ff.offset);
      ADDR_ON: nxt_prdata = 32'(par_ff.on_thr);
      ADDR_DELTA: nxt_prdata = 32'(par_ff.delta);
      ADDR_STATUS: nxt_prdata = {31'h0000_0000, q_ff};
      ADDR_ACT_X: nxt_prdata = act_x_ff;
      ADDR_ACT_Y: nxt_prdata = act_y_ff;
      default: nxt_slverr = 1'b1;
    endcase
  end

  // The answer is prepared in the setup cycle, so every access is zero wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && nxt_slverr;
      prdata_ff <= (setup && !pwrite) ? nxt_prdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= CTRL_RST;
      par_ff.gain <= 11'(GAIN_UNITY);
      par_ff.offset <= 15'sh0000;
      par_ff.on_thr <= ZERO16;
      par_ff.delta <= ZERO16;
    end else if (wr_take) begin
      case (paddr)
        ADDR_CTRL: cfg_ff <= pwdata;
        ADDR_GAIN: par_ff.gain <= 11'(clamp(pwdata, GAIN_MIN, GAIN_MAX));
        ADDR_OFFSET: par_ff.offset <= 15'(clamp(pwdata, OFS_MIN, OFS_MAX));
        ADDR_ON: par_ff.on_thr <= 16'(clamp(pwdata, THR_MIN, THR_MAX));
        ADDR_DELTA: par_ff.delta <= 16'(clamp(pwdata, THR_MIN, THR_MAX));
        default: ;
      endcase
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ****************************************************************
  // Input channels
  // ****************************************************************
  logic signed [15:0] phys_val_ff [PHYS_CH];

  genvar gi;
  generate
    for (gi = 0; gi < PHYS_CH; gi++) begin : g_phys
      logic [31:0] code;
      assign code = 32'(physical_analog_channels[gi*ADC_W +: ADC_W]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          phys_val_ff[gi] <= ZERO16;
        end else begin
          phys_val_ff[gi] <= 16'((code * PHYS_SPAN) / ADC_FULL);
        end
      end
    end
  endgenerate

  function automatic logic signed [15:0] pick(input logic [5:0] sel,
                                              input logic signed [15:0] ph [PHYS_CH],
                                              input logic [NET_CH*16-1:0] net,
                                              input logic [BLK_CH*16-1:0] blk);
    logic signed [15:0] r;
    logic [5:0] k;
    r = ZERO16;
    k = 6'h00;
    if (sel < SRC_NET_BASE) begin
      r = ph[sel[2:0]];
    end else if (sel < SRC_BLK_BASE) begin
      k = sel - SRC_NET_BASE;
      r = net[k[4:0]*16 +: 16];
    end else if (sel <= SRC_LAST) begin
      k = sel - SRC_BLK_BASE;
      r = blk[k[2:0]*16 +: 16];
    end
    return r;
  endfunction

  // ****************************************************************
  // Scaling
  // ****************************************************************
  logic signed [15:0] raw_x;
  logic signed [15:0] raw_y;
  logic signed [31:0] nxt_act_x;
  logic signed [31:0] nxt_act_y;

  assign raw_x = pick(cfg_ff.x_sel, phys_val_ff, network_analog_channels, block_values);
  assign raw_y = pick(cfg_ff.y_sel, phys_val_ff, network_analog_channels, block_values);

  // Products stay within 27 bits, so 32-bit signed math cannot overflow.
  assign nxt_act_x = (32'(raw_x) * 32'(par_ff.gain)) / GAIN_UNITY
                     + 32'(par_ff.offset);
  assign nxt_act_y = (32'(raw_y) * 32'(par_ff.gain)) / GAIN_UNITY
                     + 32'(par_ff.offset);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_x_ff <= 32'sh0000_0000;
      act_y_ff <= 32'sh0000_0000;
    end else begin
      act_x_ff <= nxt_act_x;
      act_y_ff <= nxt_act_y;
    end
  end

  // ****************************************************************
  // Threshold decision
  // ****************************************************************
  logic signed [32:0] cmp_val;
  logic signed [32:0] on_val;
  logic signed [32:0] off_val;
  logic nxt_q;

  always_comb begin
    cmp_val = 33'(act_x_ff);
    on_val = 33'(par_ff.on_thr);
    off_val = 33'(par_ff.on_thr) + 33'(par_ff.delta);
    if (cfg_ff.mode != ATT_DIFF_TRIG) begin
      cmp_val = 33'(act_x_ff) - 33'(act_y_ff);
    end
    if (cfg_ff.mode == ATT_COMPARE) begin
      off_val = 33'(par_ff.delta);
      if (cfg_ff.on_from_blk) begin
        on_val = 33'($signed(block_values[cfg_ff.on_blk*16 +: 16]));
      end
      if (cfg_ff.off_from_blk) begin
        off_val = 33'($signed(block_values[cfg_ff.off_blk*16 +: 16]));
      end
    end
    nxt_q = q_ff;
    if (cfg_ff.mode == ATT_REDUCED) begin
      nxt_q = cmp_val > 33'(par_ff.delta);
    end else if (on_val >= off_val) begin
      if (cmp_val > on_val) begin
        nxt_q = 1'b1;
      end else if (cmp_val <= off_val) begin
        nxt_q = 1'b0;
      end
    end else begin
      nxt_q = (cmp_val >= on_val) && (cmp_val < off_val);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= 1'b0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign trig_q = q_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_gain_clamp;
    @(posedge pclk) disable iff (!presetn)
      (wr_take && paddr == ADDR_GAIN && $signed(pwdata) > GAIN_MAX)
      |=> (par_ff.gain == 11'(GAIN_MAX));
  endproperty
  a_gain_clamp: assert property (p_gain_clamp) else $error("gain not clamped");

  property p_thr_clamp;
    @(posedge pclk) disable iff (!presetn)
      (wr_take && paddr == ADDR_ON && $signed(pwdata) < THR_MIN)
      |=> (par_ff.on_thr == 16'(THR_MIN));
  endproperty
  a_thr_clamp: assert property (p_thr_clamp) else $error("on threshold not clamped");

  property p_scale;
    @(posedge pclk) disable iff (!presetn)
      presetn |=> ((($past(raw_x) == ZERO16) |-> (act_x_ff == 32'($past(par_ff.offset))))
                  and (($past(par_ff.gain) == 11'(GAIN_UNITY))
                       |-> (act_x_ff == 32'($past(raw_x)) + 32'($past(par_ff.offset)))));
  endproperty
  a_scale: assert property (p_scale) else $error("scaled value wrong");

  property p_neg_set;
    @(posedge pclk) disable iff (!presetn)
      (cfg_ff.mode == ATT_DIFF_TRIG && par_ff.delta < ZERO16 && cmp_val > on_val)
      |=> q_ff;
  endproperty
  a_neg_set: assert property (p_neg_set) else $error("output not set above on");

  property p_neg_clr;
    @(posedge pclk) disable iff (!presetn)
      (cfg_ff.mode != ATT_REDUCED && on_val >= off_val && cmp_val <= off_val)
      |=> !q_ff;
  endproperty
  a_neg_clr: assert property (p_neg_clr) else $error("output not cleared");

  property p_window;
    @(posedge pclk) disable iff (!presetn)
      (cfg_ff.mode != ATT_REDUCED && on_val < off_val)
      |=> (q_ff == ($past(cmp_val) >= $past(on_val) && $past(cmp_val) < $past(off_val)));
  endproperty
  a_window: assert property (p_window) else $error("window output wrong");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      (cfg_ff.mode != ATT_REDUCED && on_val >= off_val && cmp_val <= on_val
       && cmp_val > off_val) |=> $stable(q_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed in hysteresis");

  property p_reduced;
    @(posedge pclk) disable iff (!presetn)
      (cfg_ff.mode == ATT_REDUCED) |=> (q_ff == ($past(cmp_val) > 33'($past(par_ff.delta))));
  endproperty
  a_reduced: assert property (p_reduced) else $error("reduced output wrong");

  property p_off_sum;
    @(posedge pclk) disable iff (!presetn)
      (cfg_ff.mode == ATT_DIFF_TRIG) |-> (off_val == 33'(par_ff.on_thr) + 33'(par_ff.delta)
                                         && cmp_val == 33'(act_x_ff));
  endproperty
  a_off_sum: assert property (p_off_sum) else $error("off threshold wrong");

  property p_blk_on;
    @(posedge pclk) disable iff (!presetn)
      (cfg_ff.mode == ATT_COMPARE && cfg_ff.on_from_blk)
      |-> (on_val == 33'($signed(block_values[cfg_ff.on_blk*16 +: 16])));
  endproperty
  a_blk_on: assert property (p_blk_on) else $error("block threshold not used");

  property p_diff;
    @(posedge pclk) disable iff (!presetn)
      (cfg_ff.mode == ATT_COMPARE) |-> (cmp_val == 33'(act_x_ff) - 33'(act_y_ff));
  endproperty
  a_diff: assert property (p_diff) else $error("difference wrong");

  property p_phys;
    @(posedge pclk) disable iff (!presetn)
      (presetn && physical_analog_channels[ADC_W-1:0] == ADC_W'(ADC_FULL))
      |=> (phys_val_ff[0] == 16'(PHYS_SPAN));
  endproperty
  a_phys: assert property (p_phys) else $error("full scale not 1000");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pready_ff) |=> pready_ff ##1 !pready_ff;
  endproperty
  a_ready: assert property (p_ready) else $error("apb ready timing wrong");

  property p_blk_off;
    @(posedge pclk) disable iff (!presetn)
      (cfg_ff.mode == ATT_COMPARE && cfg_ff.off_from_blk)
      |-> (off_val == 33'($signed(block_values[cfg_ff.off_blk*16 +: 16])));
  endproperty
  a_blk_off: assert property (p_blk_off) else $error("block off threshold not used");

  property p_slverr;
    @(posedge pclk) disable iff (!presetn)
      (setup && (paddr[1:0] != 2'b00 || paddr > ADDR_ACT_Y))
      |=> (pslverr_ff && prdata_ff == 32'h0000_0000);
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped address not refused");

  property p_rdata_idle;
    @(posedge pclk) disable iff (!presetn)
      !pready_ff |-> (prdata_ff == 32'h0000_0000 && !pslverr_ff);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");

endmodule

// ### att_src_model.sv
`timescale 1ns/100ps
// ****************************************
// Analog sources seen by the threshold unit
// ****************************************
module att_src_model
  import att_pkg::*;
(
  output logic [PHYS_CH*ADC_W-1:0] physical_analog_channels, // Converter codes
  output logic [NET_CH*16-1:0] network_analog_channels, // Network values
  output logic [BLK_CH*16-1:0] block_values // Block actual values
);
  logic [ADC_W-1:0] ph [PHYS_CH] = '{default: '0};
  logic signed [15:0] net [NET_CH] = '{default: '0};
  logic signed [15:0] blk [BLK_CH] = '{default: '0};

  always_comb begin
    for (int i = 0; i < PHYS_CH; i++) begin
      physical_analog_channels[i*ADC_W +: ADC_W] = ph[i];
    end
    for (int i = 0; i < NET_CH; i++) begin
      network_analog_channels[i*16 +: 16] = net[i];
    end
    for (int i = 0; i < BLK_CH; i++) begin
      block_values[i*16 +: 16] = blk[i];
    end
  end

  task automatic set_ph(input int i, input logic [ADC_W-1:0] v);
    ph[i] <= v;
  endtask

  task automatic set_net(input int i, input logic [15:0] v);
    net[i] <= v;
  endtask

  task automatic set_blk(input int i, input logic [15:0] v);
    blk[i] <= v;
  endtask
endmodule

// ### testbench.sv
`timescale 1ns/100ps
// ****************************************
// Self-checking bench of the threshold unit
// ****************************************
module testbench;
  import att_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic trig_q;
  logic [PHYS_CH*ADC_W-1:0] phys_w;
  logic [NET_CH*16-1:0] net_w;
  logic [BLK_CH*16-1:0] blk_w;
  int seed = 32'hFEBF;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int g, o, on, dl, m, r;
  att_cfg_t cfg;
  logic qe = 1'b0;
  logic kn = 1'b0;
  logic [31:0] rd;
  logic er;
  int hv [9] = '{150, 75, 50, 75, 100, 100, 149, 150, 99};

  att_trigger att_trigger_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .physical_analog_channels(phys_w), .network_analog_channels(net_w),
    .block_values(blk_w), .trig_q(trig_q));
  att_src_model att_src_model_i (.physical_analog_channels(phys_w),
    .network_analog_channels(net_w), .block_values(blk_w));

  always #20 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, er}, 32'h0000_0000);
  endtask

  function automatic int clampv(int v, int lo, int hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic int rnd(int s);
    return $random(seed) % (s + 1);
  endfunction

  function automatic int raw(logic [5:0] s);
    if (s < SRC_NET_BASE) begin
      return int'(att_src_model_i.ph[s[2:0]]) * int'(PHYS_SPAN) / int'(ADC_FULL);
    end
    if (s < SRC_BLK_BASE) begin
      return att_src_model_i.net[s - SRC_NET_BASE];
    end
    if (s > SRC_LAST) begin
      return 0;
    end
    return att_src_model_i.blk[s[2:0]];
  endfunction

  function automatic int act(logic [5:0] s);
    return raw(s) * g / GAIN_UNITY + o;
  endfunction

  task automatic setcfg(int gi, int oi, int oni, int dli);
    g = clampv(gi, GAIN_MIN, GAIN_MAX);
    o = clampv(oi, OFS_MIN, OFS_MAX);
    on = clampv(oni, THR_MIN, THR_MAX);
    dl = clampv(dli, THR_MIN, THR_MAX);
    apb(1'b1, ADDR_CTRL, cfg);
    apb(1'b1, ADDR_GAIN, gi);
    apb(1'b1, ADDR_OFFSET, oi);
    apb(1'b1, ADDR_ON, oni);
    apb(1'b1, ADDR_DELTA, dli);
    rdc(ADDR_CTRL, cfg);
    rdc(ADDR_GAIN, g);
    rdc(ADDR_OFFSET, o);
    rdc(ADDR_ON, on);
    rdc(ADDR_DELTA, dl);
    kn = 1'b0;
  endtask

  task automatic step();
    int x, y, v, a, b;
    logic [1:0] q2;
    repeat (4) @(posedge pclk);
    x = act(cfg.x_sel);
    y = act(cfg.y_sel);
    v = (cfg.mode == ATT_DIFF_TRIG) ? x : x - y;
    a = (cfg.mode == ATT_COMPARE && cfg.on_from_blk) ? att_src_model_i.blk[cfg.on_blk] : on;
    b = (cfg.mode == ATT_COMPARE || cfg.mode == ATT_REDUCED) ? dl : on + dl;
    if (cfg.mode == ATT_COMPARE && cfg.off_from_blk) begin
      b = att_src_model_i.blk[cfg.off_blk];
    end
    if (cfg.mode == ATT_REDUCED) begin
      q2 = {1'b1, v > b};
    end else if (a >= b) begin
      q2 = (v > a) ? 2'b11 : ((v <= b) ? 2'b10 : {1'b0, qe});
    end else begin
      q2 = {1'b1, v >= a && v < b};
    end
    kn = kn | q2[1];
    qe = q2[0];
    if (kn) begin
      chk(trig_q, qe);
      rdc(ADDR_STATUS, qe);
    end
    rdc(ADDR_ACT_X, x);
    rdc(ADDR_ACT_Y, y);
  endtask

  task automatic shuffle(input logic all);
    for (int i = 0; i < NET_CH; i++) begin
      att_src_model_i.set_net(i, 16'(rnd(2000)));
    end
    for (int i = 0; i < BLK_CH && all; i++) begin
      att_src_model_i.set_ph(i, ADC_W'($random(seed)));
      att_src_model_i.set_blk(i, 16'(rnd(2000)));
    end
  endtask

  function automatic logic [5:0] pick();
    r = $random(seed) & 63;
    return (r > 47 && r < 56) ? 6'(r - 16) : 6'(r);
  endfunction

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(trig_q, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      rdc(8'(4 * i), (i == 1) ? GAIN_UNITY : 32'h0000_0000);
    end
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({rd[30:0], er}, 32'h0000_0001);
    $display("test registers done");
    cfg = CTRL_RST;
    cfg.x_sel = SRC_NET_BASE;
    cfg.decimals = 2'h3;
    for (int i = 0; i < 9; i++) begin
      if (i == 0 || i == 5) begin
        setcfg(100, 0, 100, (i == 0) ? -50 : 50);
      end
      att_src_model_i.set_net(0, 16'(hv[i]));
      step();
    end
    cfg.x_sel = 6'h00;
    att_src_model_i.set_ph(0, 12'hFFF);
    setcfg(-2000, -30000, -25000, 25000);
    step();
    presetn <= 1'b0;
    @(posedge pclk);
    chk(trig_q, 32'h0000_0000);
    presetn <= 1'b1;
    rdc(ADDR_GAIN, GAIN_UNITY);
    $display("test corners done");
    repeat (30) begin
      m = $random(seed) & 3;
      cfg = $random(seed);
      cfg.mode = att_mode_t'(m);
      cfg.x_sel = pick();
      cfg.y_sel = pick();
      if (cfg.mode != ATT_COMPARE) begin
        cfg.on_from_blk = 1'b0;
        cfg.off_from_blk = 1'b0;
      end
      shuffle(1'b1);
      setcfg(rnd(1200), rnd(12000), rnd(2000), rnd(1500));
      step();
      repeat (6) begin
        shuffle(1'b0);
        step();
      end
    end
    $display("test random done");
    results();
  end
endmodule
